/* hw/dtm_debounce.sv */
// Synchroniser and debounce filter for one safety channel
`timescale 1ns/10ps
`default_nettype none
module dtm_debounce
    import dtm_pkg::*;
#(
    parameter int CYCLES = DEBOUNCE_CYCLES
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic raw,
    output logic clean,
    output logic settled
);

    localparam int CW = $clog2(CYCLES + 1);

    logic sync_first;
    logic sync_second;
    logic [CW-1:0] stable_count;

    // =========================================================
    // Two-stage synchroniser
    // =========================================================
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            sync_first <= CHANNEL_OPEN;
            sync_second <= CHANNEL_OPEN;
        end else begin
            sync_first <= raw;
            sync_second <= sync_first;
        end
    end

    // =========================================================
    // Stability filter
    // =========================================================
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            stable_count <= '0;
            clean <= CHANNEL_OPEN;
        end else if (sync_second == clean) begin
            stable_count <= '0;
        end else if (stable_count == CW'(CYCLES - 1)) begin
            stable_count <= '0;
            clean <= sync_second;
        end else begin
            stable_count <= stable_count + 1'b1;
        end
    end

    // Settled once the filter time has passed and no change is pending,
    // so a closed channel is never decoded as open after power-up
    logic [CW-1:0] settle_count;
    logic settle_done;
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            settle_count <= '0;
            settle_done <= 1'b0;
            settled <= 1'b0;
        end else begin
            if (!settle_done) begin
                if (settle_count == CW'(CYCLES - 1)) begin
                    settle_done <= 1'b1;
                end else begin
                    settle_count <= settle_count + 1'b1;
                end
            end
            if (settle_done && sync_second == clean) begin
                settled <= 1'b1;
            end
        end
    end

    // =========================================================
    // Checks
    // =========================================================
    property p_filter_change;
        @(posedge mclk) disable iff (!rst_n)
        $changed(clean) |-> $past(stable_count) == CW'(CYCLES - 1);
    endproperty
    a_filter_change: assert property (p_filter_change)
        else $error("channel filter changed before stable time");

endmodule : dtm_debounce
`default_nettype wire

/* hw/dtm_monitor.sv */
// Dual-channel safe-torque-off monitor, top level
`timescale 1ns/10ps
`default_nettype none
module dtm_monitor
    import dtm_pkg::*;
#(
    parameter int DEB_CYCLES = DEBOUNCE_CYCLES,
    parameter int DISC_CYCLES = DISCREPANCY_CYCLES
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic safety_channel_a,
    input wire logic safety_channel_b,
    input wire logic start_cmd,
    input wire logic stop_cmd,
    input wire logic fault_clear,
    input wire logic other_fault,
    output logic drive_enable,
    output logic trip_active,
    output logic trip_indicate,
    output dtm_code_type fault_code,
    output logic lockout
);

    localparam int DW = $clog2(DISC_CYCLES + 1);

    logic chan_a;
    logic chan_b;
    logic settled_a;
    logic settled_b;
    dtm_state_type state;
    dtm_state_type next_state;
    logic [DW-1:0] disc_count;
    logic abn_a;
    logic abn_b;
    logic a_open_only;
    logic b_open_only;
    logic both_closed;
    logic both_open;
    logic ready;

    // =========================================================
    // Channel conditioning
    // =========================================================
    dtm_debounce #(.CYCLES(DEB_CYCLES)) u_deb_a (
        .mclk(mclk),
        .rst_n(rst_n),
        .raw(safety_channel_a),
        .clean(chan_a),
        .settled(settled_a)
    );

    dtm_debounce #(.CYCLES(DEB_CYCLES)) u_deb_b (
        .mclk(mclk),
        .rst_n(rst_n),
        .raw(safety_channel_b),
        .clean(chan_b),
        .settled(settled_b)
    );

    assign both_closed = (chan_a == CHANNEL_CLOSED) &&
                         (chan_b == CHANNEL_CLOSED);
    assign both_open = (chan_a == CHANNEL_OPEN) && (chan_b == CHANNEL_OPEN);
    assign a_open_only = (chan_a == CHANNEL_OPEN) &&
                         (chan_b == CHANNEL_CLOSED);
    assign b_open_only = (chan_a == CHANNEL_CLOSED) &&
                         (chan_b == CHANNEL_OPEN);
    assign ready = settled_a && settled_b;

    // =========================================================
    // Trip state machine
    // =========================================================
    always_comb begin
        next_state = state;
        case (state)
            DTM_ST_POWER_UP: begin
                if (ready && both_closed) begin
                    next_state = DTM_ST_RUN;
                end else if (ready && both_open) begin
                    next_state = DTM_ST_TRIP;
                end else if (ready) begin
                    next_state = DTM_ST_DISAGREE;
                end
            end
            DTM_ST_RUN: begin
                if (both_open) begin
                    next_state = DTM_ST_TRIP;
                end else if (!both_closed) begin
                    next_state = DTM_ST_DISAGREE;
                end
            end
            DTM_ST_DISAGREE: begin
                // Contacts get the discrepancy time to move together
                if (both_open) begin
                    next_state = DTM_ST_TRIP;
                end else if (both_closed ||
                             disc_count == DW'(DISC_CYCLES - 1)) begin
                    next_state = DTM_ST_LOCK;
                end
            end
            DTM_ST_TRIP: begin
                // Contacts reclosing with skew stay in the clearable trip
                if (fault_clear && both_closed) begin
                    next_state = DTM_ST_RUN;
                end
            end
            DTM_ST_LOCK: begin
                next_state = DTM_ST_LOCK;
            end
            default: begin
                next_state = DTM_ST_LOCK;
            end
        endcase
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state <= DTM_ST_POWER_UP;
        end else begin
            state <= next_state;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            disc_count <= '0;
        end else if (state != DTM_ST_DISAGREE) begin
            disc_count <= '0;
        end else if (disc_count != DW'(DISC_CYCLES - 1)) begin
            disc_count <= disc_count + 1'b1;
        end
    end

    // =========================================================
    // Abnormal channel record, kept until power-up
    // =========================================================
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            abn_a <= 1'b0;
            abn_b <= 1'b0;
        end else if (state == DTM_ST_DISAGREE &&
                     next_state == DTM_ST_LOCK) begin
            // Mark the channel that was open alone, also on early reclose
            abn_a <= abn_a || a_open_only ||
                     (both_closed && $past(chan_a) == CHANNEL_OPEN);
            abn_b <= abn_b || b_open_only ||
                     (both_closed && $past(chan_b) == CHANNEL_OPEN);
        end else if (state == DTM_ST_LOCK) begin
            // A later disagreement on the other channel marks both
            if (a_open_only) begin
                abn_a <= 1'b1;
            end
            if (b_open_only) begin
                abn_b <= 1'b1;
            end
        end
    end

    // =========================================================
    // Drive output and run latch
    // =========================================================
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            drive_enable <= 1'b0;
        end else if (next_state != DTM_ST_RUN) begin
            drive_enable <= 1'b0;
        end else if (stop_cmd || other_fault) begin
            drive_enable <= 1'b0;
        end else if (start_cmd && state == DTM_ST_RUN) begin
            drive_enable <= 1'b1;
        end
    end

    // =========================================================
    // Indication
    // =========================================================
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            fault_code <= DTM_CODE_NONE;
            trip_active <= 1'b1;
            trip_indicate <= 1'b0;
            lockout <= 1'b0;
        end else begin
            trip_active <= (next_state != DTM_ST_RUN);
            lockout <= (next_state == DTM_ST_LOCK);
            case (next_state)
                DTM_ST_TRIP: begin
                    fault_code <= DTM_CODE_E40;
                    trip_indicate <= 1'b1;
                end
                DTM_ST_LOCK: begin
                    trip_indicate <= 1'b1;
                    if ((abn_a || a_open_only) && (abn_b || b_open_only)) begin
                        fault_code <= DTM_CODE_E43;
                    end else if (abn_b || b_open_only) begin
                        fault_code <= DTM_CODE_E42;
                    end else begin
                        fault_code <= DTM_CODE_E41;
                    end
                end
                DTM_ST_RUN: begin
                    fault_code <= DTM_CODE_NONE;
                    trip_indicate <= 1'b0;
                end
                default: begin
                    fault_code <= fault_code;
                    trip_indicate <= trip_indicate;
                end
            endcase
        end
    end

    // =========================================================
    // Checks
    // =========================================================
    int trip_age;
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            trip_age <= 0;
        end else if (state == DTM_ST_RUN || state == DTM_ST_POWER_UP) begin
            trip_age <= 0;
        end else if (trip_age < INDICATE_ABNORMAL_CYCLES) begin
            trip_age <= trip_age + 1;
        end
    end

    property p_run_no_code;
        @(posedge mclk) disable iff (!rst_n)
        state == DTM_ST_RUN |-> fault_code == DTM_CODE_NONE && !trip_active;
    endproperty
    a_run_no_code: assert property (p_run_no_code)
        else $error("fault shown while running");

    property p_both_open_trip;
        @(posedge mclk) disable iff (!rst_n)
        state == DTM_ST_RUN && both_open |=>
            state == DTM_ST_TRIP && fault_code == DTM_CODE_E40;
    endproperty
    a_both_open_trip: assert property (p_both_open_trip)
        else $error("both open did not give E40");

    property p_a_abnormal;
        @(posedge mclk) disable iff (!rst_n)
        state == DTM_ST_DISAGREE && a_open_only && !abn_b &&
        disc_count == DW'(DISC_CYCLES - 1) |=> fault_code == DTM_CODE_E41;
    endproperty
    a_a_abnormal: assert property (p_a_abnormal)
        else $error("channel A fault not shown");

    property p_b_abnormal;
        @(posedge mclk) disable iff (!rst_n)
        state == DTM_ST_DISAGREE && b_open_only && !abn_a &&
        disc_count == DW'(DISC_CYCLES - 1) |=> fault_code == DTM_CODE_E42;
    endproperty
    a_b_abnormal: assert property (p_b_abnormal)
        else $error("channel B fault not shown");

    property p_both_abnormal;
        @(posedge mclk) disable iff (!rst_n)
        state == DTM_ST_LOCK && abn_a && abn_b |=> fault_code == DTM_CODE_E43;
    endproperty
    a_both_abnormal: assert property (p_both_abnormal)
        else $error("both channels abnormal not shown");

    property p_switch_off;
        @(posedge mclk) disable iff (!rst_n)
        !both_closed |=> !drive_enable;
    endproperty
    a_switch_off: assert property (p_switch_off)
        else $error("drive on with a channel open");

    property p_indicate;
        @(posedge mclk) disable iff (!rst_n)
        trip_age >= INDICATE_ABNORMAL_CYCLES - 1 |-> trip_indicate;
    endproperty
    a_indicate: assert property (p_indicate)
        else $error("trip not indicated in time");

    property p_start_ignored;
        @(posedge mclk) disable iff (!rst_n)
        state != DTM_ST_RUN && start_cmd |=> !drive_enable;
    endproperty
    a_start_ignored: assert property (p_start_ignored)
        else $error("start accepted during trip");

    property p_clear_open;
        @(posedge mclk) disable iff (!rst_n)
        state == DTM_ST_TRIP && fault_clear && both_open |=>
            state == DTM_ST_TRIP ##1 !drive_enable;
    endproperty
    a_clear_open: assert property (p_clear_open)
        else $error("clear accepted with channels open");

    property p_lock_holds;
        @(posedge mclk) disable iff (!rst_n)
        state == DTM_ST_LOCK |=> state == DTM_ST_LOCK && lockout;
    endproperty
    a_lock_holds: assert property (p_lock_holds)
        else $error("lockout left without power-up");

    property p_clear_closed;
        @(posedge mclk) disable iff (!rst_n)
        state == DTM_ST_TRIP && fault_clear && both_closed |=>
            state == DTM_ST_RUN ##1 fault_code == DTM_CODE_NONE;
    endproperty
    a_clear_closed: assert property (p_clear_closed)
        else $error("E40 not cleared by reset key");

    property p_override;
        @(posedge mclk) disable iff (!rst_n)
        other_fault |=> !drive_enable;
    endproperty
    a_override: assert property (p_override)
        else $error("drive on during other fault");

    c_normal_trip: cover property (@(posedge mclk) disable iff (!rst_n)
        state == DTM_ST_TRIP ##1 state == DTM_ST_RUN);
    c_lock_a: cover property (@(posedge mclk) disable iff (!rst_n)
        fault_code == DTM_CODE_E41);
    c_lock_b: cover property (@(posedge mclk) disable iff (!rst_n)
        fault_code == DTM_CODE_E42);
    c_run: cover property (@(posedge mclk) disable iff (!rst_n)
        drive_enable);

endmodule : dtm_monitor
`default_nettype wire

/* hw/dtm_pkg.sv */
// Shared constants and types of the dual-channel torque-off monitor
package dtm_pkg;

    // =========================================================
    // Clock and timing
    // =========================================================
    localparam int CLK_PERIOD_NS = 10;
    localparam int NS_PER_US = 1000;
    localparam int NS_PER_MS = 1000000;
    localparam int SYNC_STAGES = 2;
    // Input filter time, well inside the switch-off budget
    localparam int DEBOUNCE_TIME_US = 1000;
    localparam int DEBOUNCE_CYCLES = DEBOUNCE_TIME_US * NS_PER_US /
                                     CLK_PERIOD_NS;
    // Time the external contacts get to move together
    localparam int DISCREPANCY_TIME_MS = 200;
    localparam int DISCREPANCY_CYCLES = DISCREPANCY_TIME_MS * NS_PER_MS /
                                        CLK_PERIOD_NS;
    localparam int TRIGGER_LIMIT_MS = 10;
    localparam int TRIGGER_LIMIT_CYCLES = TRIGGER_LIMIT_MS * NS_PER_MS /
                                          CLK_PERIOD_NS;
    localparam int INDICATE_NORMAL_MS = 100;
    localparam int INDICATE_NORMAL_CYCLES = INDICATE_NORMAL_MS * NS_PER_MS /
                                            CLK_PERIOD_NS;
    localparam int INDICATE_ABNORMAL_MS = 280;
    localparam int INDICATE_ABNORMAL_CYCLES = INDICATE_ABNORMAL_MS *
                                              NS_PER_MS / CLK_PERIOD_NS;

    // =========================================================
    // Channel levels
    // =========================================================
    localparam logic CHANNEL_CLOSED = 1'b1;
    localparam logic CHANNEL_OPEN = 1'b0;

    // =========================================================
    // Types
    // =========================================================
    typedef enum logic [2:0] {
        DTM_CODE_NONE,
        DTM_CODE_E40,
        DTM_CODE_E41,
        DTM_CODE_E42,
        DTM_CODE_E43
    } dtm_code_type;

    typedef enum logic [2:0] {
        DTM_ST_POWER_UP,
        DTM_ST_RUN,
        DTM_ST_DISAGREE,
        DTM_ST_TRIP,
        DTM_ST_LOCK
    } dtm_state_type;

endpackage : dtm_pkg

/* verification/dtm_monitor_test.sv */
// Self-checking bench of the dual-channel torque-off monitor
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin \
    n_mismatch++; \
    $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g); end end
module dtm_monitor_test;
    import dtm_pkg::*;

    // =========================================================
    // Signals
    // =========================================================
    localparam int DEB = 4;
    localparam int DISC = 20;
    typedef struct packed {
        logic de;
        logic ta;
        logic ti;
        dtm_code_type fc;
        logic lk;
    } dtm_exp_type;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic start_cmd = 1'b0;
    logic stop_cmd = 1'b0;
    logic fault_clear = 1'b0;
    logic other_fault = 1'b0;
    logic open_a = 1'b0;
    logic open_b = 1'b0;
    logic [7:0] skew = 8'h00;
    logic [7:0] lfsr = 8'h32;
    logic safety_channel_a;
    logic safety_channel_b;
    logic drive_enable;
    logic trip_active;
    logic trip_indicate;
    dtm_code_type fault_code;
    logic lockout;
    dtm_exp_type exp_q[$];
    int n_mismatch = 0;
    int cmp_count = 0;
    int cycles = 0;

    initial begin
        forever #5 mclk = ~mclk;
    end

    dtm_switch_model #(.MAX_SKEW(DISC)) u_switch (
        .mclk(mclk), .want_open_a(open_a), .want_open_b(open_b),
        .skew(skew), .safety_channel_a(safety_channel_a),
        .safety_channel_b(safety_channel_b)
    );

    dtm_monitor #(.DEB_CYCLES(DEB), .DISC_CYCLES(DISC)) DUT (
        .mclk(mclk), .rst_n(rst_n),
        .safety_channel_a(safety_channel_a),
        .safety_channel_b(safety_channel_b),
        .start_cmd(start_cmd), .stop_cmd(stop_cmd),
        .fault_clear(fault_clear), .other_fault(other_fault),
        .drive_enable(drive_enable), .trip_active(trip_active),
        .trip_indicate(trip_indicate), .fault_code(fault_code),
        .lockout(lockout)
    );

    // =========================================================
    // Tasks
    // =========================================================
    function automatic logic [7:0] lfsr_next(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction : lfsr_next

    task automatic cyc(input int n);
        repeat (n) @(negedge mclk);
    endtask : cyc

    task automatic expect_out(input logic de, input logic ta,
                              input logic ti, input dtm_code_type fc,
                              input logic lk);
        @(posedge mclk);
        #1;
        exp_q.push_back('{de, ta, ti, fc, lk});
        cyc(1);
    endtask : expect_out

    task automatic pulse_start();
        start_cmd = 1'b1;
        cyc(1);
        start_cmd = 1'b0;
        cyc(1);
    endtask : pulse_start

    task automatic pulse_clear();
        fault_clear = 1'b1;
        cyc(1);
        fault_clear = 1'b0;
        cyc(1);
    endtask : pulse_clear

    task automatic power_cycle();
        rst_n = 1'b0;
        expect_out(1'b0, 1'b1, 1'b0, DTM_CODE_NONE, 1'b0);
        cyc(4);
        rst_n = 1'b1;
        cyc(DEB + 10);
    endtask : power_cycle

    task automatic final_report();
        $display("Comparisons %0d, mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : final_report

    // =========================================================
    // Output watcher
    // =========================================================
    always @(negedge mclk) begin
        dtm_exp_type e;
        if (exp_q.size() != 0) begin
            e = exp_q.pop_front();
            `CHK("drive_enable", e.de, drive_enable)
            `CHK("trip_active", e.ta, trip_active)
            `CHK("trip_indicate", e.ti, trip_indicate)
            `CHK("fault_code", e.fc, fault_code)
            `CHK("lockout", e.lk, lockout)
        end
    end

    always @(posedge mclk) begin
        cycles++;
        if (cycles == 3000) begin
            n_mismatch++;
            final_report();
        end
    end

    // =========================================================
    // Scenarios
    // =========================================================
    initial begin
        cyc(5);
        rst_n = 1'b1;
        cyc(DEB + 10);
        expect_out(1'b0, 1'b0, 1'b0, DTM_CODE_NONE, 1'b0);
        pulse_start();
        expect_out(1'b1, 1'b0, 1'b0, DTM_CODE_NONE, 1'b0);
        other_fault = 1'b1;
        cyc(2);
        expect_out(1'b0, 1'b0, 1'b0, DTM_CODE_NONE, 1'b0);
        other_fault = 1'b0;
        pulse_start();
        stop_cmd = 1'b1;
        cyc(2);
        stop_cmd = 1'b0;
        expect_out(1'b0, 1'b0, 1'b0, DTM_CODE_NONE, 1'b0);
        pulse_start();
        // Both contacts open with a small skew while running
        skew = 8'h03;
        open_a = 1'b1;
        open_b = 1'b1;
        cyc(DEB + 20);
        expect_out(1'b0, 1'b1, 1'b1, DTM_CODE_E40, 1'b0);
        repeat (8) begin
            lfsr = lfsr_next(lfsr);
            start_cmd = lfsr[0];
            cyc(1);
        end
        start_cmd = 1'b0;
        expect_out(1'b0, 1'b1, 1'b1, DTM_CODE_E40, 1'b0);
        pulse_clear();
        pulse_start();
        expect_out(1'b0, 1'b1, 1'b1, DTM_CODE_E40, 1'b0);
        open_a = 1'b0;
        open_b = 1'b0;
        cyc(DEB + 20);
        expect_out(1'b0, 1'b1, 1'b1, DTM_CODE_E40, 1'b0);
        pulse_clear();
        expect_out(1'b0, 1'b0, 1'b0, DTM_CODE_NONE, 1'b0);
        pulse_start();
        expect_out(1'b1, 1'b0, 1'b0, DTM_CODE_NONE, 1'b0);
        // Contact A alone opens
        open_a = 1'b1;
        cyc(DEB + 6);
        expect_out(1'b0, 1'b1, 1'b0, DTM_CODE_NONE, 1'b0);
        cyc(DISC + 10);
        expect_out(1'b0, 1'b1, 1'b1, DTM_CODE_E41, 1'b1);
        open_a = 1'b0;
        cyc(DEB + 10);
        pulse_clear();
        pulse_start();
        expect_out(1'b0, 1'b1, 1'b1, DTM_CODE_E41, 1'b1);
        open_b = 1'b1;
        cyc(DISC + DEB + 20);
        expect_out(1'b0, 1'b1, 1'b1, DTM_CODE_E43, 1'b1);
        open_b = 1'b0;
        power_cycle();
        expect_out(1'b0, 1'b0, 1'b0, DTM_CODE_NONE, 1'b0);
        // Contact B alone opens
        open_b = 1'b1;
        cyc(DISC + DEB + 20);
        expect_out(1'b0, 1'b1, 1'b1, DTM_CODE_E42, 1'b1);
        open_b = 1'b0;
        power_cycle();
        pulse_start();
        expect_out(1'b1, 1'b0, 1'b0, DTM_CODE_NONE, 1'b0);
        cyc(2);
        final_report();
    end
endmodule : dtm_monitor_test
`default_nettype wire

/* verification/dtm_switch_model.sv */
// External two-contact safety switch that drives both channel inputs
`timescale 1ns/10ps
`default_nettype none
module dtm_switch_model #(
    parameter int MAX_SKEW = 20
) (
    input wire logic mclk,
    input wire logic want_open_a,
    input wire logic want_open_b,
    input wire logic [7:0] skew,
    output logic safety_channel_a,
    output logic safety_channel_b
);
    // =========================================================
    // Contact motion
    // =========================================================
    logic [7:0] lag;

    initial begin
        safety_channel_a = 1'b1;
        safety_channel_b = 1'b1;
        lag = 8'h00;
    end

    // Contact B trails contact A by a bounded skew
    always @(negedge mclk) begin
        safety_channel_a <= ~want_open_a;
        if (safety_channel_b == want_open_b) begin
            if (lag >= skew || lag >= 8'(MAX_SKEW)) begin
                safety_channel_b <= ~want_open_b;
                lag <= 8'h00;
            end else begin
                lag <= lag + 8'h01;
            end
        end else begin
            lag <= 8'h00;
        end
    end
endmodule : dtm_switch_model
`default_nettype wire
